/* logic/bcse_pkg.sv */
`default_nettype none
package bcse_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        BCSE_IDLE = 2'b00,  // no bus cycle, status pins parked high
        BCSE_SEND = 2'b01,  // send-status phase, status pins low
        BCSE_CMD = 2'b10    // command phase, status back high, selects held
    } bcse_state_t;

    // status pair encodings (hi, lo), active low
    localparam logic [1:0] BCSE_STATUS_INT_ACK = 2'h0;
    localparam logic [1:0] BCSE_STATUS_RSVD_A = 2'h1;
    localparam logic [1:0] BCSE_STATUS_RSVD_B = 2'h2;
    localparam logic [1:0] BCSE_STATUS_NONE = 2'h3;

    // timer width in bits, phase lengths in clock cycles
    localparam int BCSE_TIMER_W = 4;
    localparam logic [3:0] BCSE_SEND_STATUS_CYCLES = 4'h1;
    localparam logic [3:0] BCSE_COMMAND_CYCLES = 4'h2;

    // values after reset
    localparam bcse_state_t BCSE_STATE_RESET = BCSE_IDLE;
    localparam logic [1:0] BCSE_STATUS_RESET = BCSE_STATUS_NONE;
endpackage
`default_nettype wire

/* logic/bcse_phase_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module bcse_phase_timer #(
    parameter int CNT_W = 4
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // control
    input wire logic i_load,
    input wire logic [CNT_W-1:0] i_load_value,
    // status
    output logic o_expired
);
    logic [CNT_W-1:0] cnt_q; // cycles left in the current phase
    logic [CNT_W-1:0] cnt_d;

    // next count: load wins, otherwise count down and stick at zero
    always_comb begin
        cnt_d = cnt_q;
        if (i_load) begin
            cnt_d = i_load_value;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - CNT_W'(1);
        end
    end

    // register the count
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // zero means the phase has run its length
    assign o_expired = (cnt_q == '0);
endmodule // bcse_phase_timer
`default_nettype wire

/* logic/bcse_status_encoder.sv */
// Behaviour
// - status pins low mark bus cycle start
// - send-status state whenever either pin is low
// - hold acknowledge releases pins, resting high
// - selects low: 00 int-ack, 01/10 reserved, 11 none
`timescale 1ns/1ns
`default_nettype none
module bcse_status_encoder
    import bcse_pkg::*;
#(
    parameter logic [3:0] SEND_CYCLES = BCSE_SEND_STATUS_CYCLES,  // length of send-status phase, at least 1
    parameter logic [3:0] CMD_CYCLES = BCSE_COMMAND_CYCLES        // length of command phase, at least 1
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // bus cycle request from the execution side
    input wire logic i_req_valid,
    input wire logic i_req_code_or_int_ack_select,
    input wire logic i_req_mem_io_select,
    input wire logic [1:0] i_req_status,
    // bus hold acknowledge
    input wire logic i_hold_ack,
    // request answer
    output logic o_req_taken,
    output logic o_req_refused,
    output logic o_busy,
    // status pins and cycle type selects
    output logic o_cycle_status_hi_n,
    output logic o_cycle_status_lo_n,
    output logic o_status_oe,
    output logic o_code_or_int_ack_select,
    output logic o_mem_io_select,
    output logic o_send_status_state
);
    bcse_state_t state_q; // sequencer state
    bcse_state_t state_d;
    logic [1:0] lat_status_q; // status of the cycle in flight
    logic [1:0] lat_status_d;
    logic lat_code_q; // code-or-int-ack select of the cycle in flight
    logic lat_code_d;
    logic lat_mem_q; // memory-or-io select of the cycle in flight
    logic lat_mem_d;
    logic load; // restart the phase timer
    logic [3:0] load_value;
    logic expired; // current phase has run out
    logic req_bad; // request carries a reserved or idle code
    logic taken_d;
    logic refused_d;

    // output registers
    logic hi_n_q, hi_n_d;
    logic lo_n_q, lo_n_d;
    logic oe_q, oe_d;
    logic code_q, code_d;
    logic mem_q, mem_d;
    logic send_q, send_d;
    logic busy_q, busy_d;
    logic taken_q, refused_q;

    // phase length counter
    bcse_phase_timer #(
        .CNT_W(BCSE_TIMER_W)
    ) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_load(load),
        .i_load_value(load_value),
        .o_expired(expired)
    );

    // a code is refused if it would put a reserved or a non-cycle pattern on the pins
    always_comb begin
        req_bad = 1'b0;
        if (i_req_status == BCSE_STATUS_NONE) begin
            req_bad = 1'b1; // 11 never starts a cycle
        end else if (!i_req_code_or_int_ack_select && !i_req_mem_io_select &&
                     (i_req_status == BCSE_STATUS_RSVD_A || i_req_status == BCSE_STATUS_RSVD_B)) begin
            req_bad = 1'b1; // reserved codes are never issued
        end
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        lat_status_d = lat_status_q;
        lat_code_d = lat_code_q;
        lat_mem_d = lat_mem_q;
        load = 1'b0;
        load_value = 4'h0;
        taken_d = 1'b0;
        unique case (state_q)
            BCSE_IDLE: begin
                // no new cycle while the bus is handed over
                if (i_req_valid && !i_hold_ack && !req_bad) begin
                    taken_d = 1'b1;
                    lat_status_d = i_req_status;
                    lat_code_d = i_req_code_or_int_ack_select;
                    lat_mem_d = i_req_mem_io_select;
                    load = 1'b1;
                    load_value = SEND_CYCLES - 4'h1;
                    state_d = BCSE_SEND; // drive status low to start the cycle
                end
            end
            BCSE_SEND: begin
                if (i_hold_ack) begin
                    state_d = BCSE_IDLE; // hold aborts; pins are released anyway
                end else if (expired) begin
                    load = 1'b1;
                    load_value = CMD_CYCLES - 4'h1;
                    state_d = BCSE_CMD;
                end
            end
            BCSE_CMD: begin
                if (i_hold_ack || expired) begin
                    state_d = BCSE_IDLE;
                end
            end
            default: begin
                state_d = BCSE_IDLE; // unused code 11 recovers to idle
            end
        endcase
        // anything not taken this cycle is reported, including requests made while busy
        refused_d = i_req_valid && !taken_d;
    end

    // pin values follow the next state, so the pins line up with the registered state
    always_comb begin
        hi_n_d = 1'b1;
        lo_n_d = 1'b1;
        oe_d = !i_hold_ack; // release during hold, pull-up gives logic one
        code_d = 1'b0;
        mem_d = 1'b0;
        if (state_d == BCSE_SEND && !i_hold_ack) begin
            hi_n_d = lat_status_d[1]; // latched type code on the pins
            lo_n_d = lat_status_d[0];
        end
        if (state_d != BCSE_IDLE) begin
            code_d = lat_code_d; // selects qualify the status
            mem_d = lat_mem_d;
        end
        send_d = !hi_n_d || !lo_n_d; // either pin low means send-status
        busy_d = (state_d != BCSE_IDLE);
    end

    // register state and outputs
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= BCSE_STATE_RESET;
            lat_status_q <= BCSE_STATUS_RESET;
            lat_code_q <= 1'b0;
            lat_mem_q <= 1'b0;
            hi_n_q <= 1'b1;
            lo_n_q <= 1'b1;
            oe_q <= 1'b0;
            code_q <= 1'b0;
            mem_q <= 1'b0;
            send_q <= 1'b0;
            busy_q <= 1'b0;
            taken_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            state_q <= state_d;
            lat_status_q <= lat_status_d;
            lat_code_q <= lat_code_d;
            lat_mem_q <= lat_mem_d;
            hi_n_q <= hi_n_d;
            lo_n_q <= lo_n_d;
            oe_q <= oe_d;
            code_q <= code_d;
            mem_q <= mem_d;
            send_q <= send_d;
            busy_q <= busy_d;
            taken_q <= taken_d;
            refused_q <= refused_d;
        end
    end

    // ports straight from flip-flops
    assign o_cycle_status_hi_n = hi_n_q;
    assign o_cycle_status_lo_n = lo_n_q;
    assign o_status_oe = oe_q;
    assign o_code_or_int_ack_select = code_q;
    assign o_mem_io_select = mem_q;
    assign o_send_status_state = send_q;
    assign o_busy = busy_q;
    assign o_req_taken = taken_q;
    assign o_req_refused = refused_q;

    // checks on driven outputs
    AST_HOLD_RELEASE: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        i_hold_ack |=> (!o_status_oe && o_cycle_status_hi_n && o_cycle_status_lo_n && !o_busy)
    ) else $error("status pins not released during hold acknowledge");

    AST_SEND_STATE: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_send_status_state == (!o_cycle_status_hi_n || !o_cycle_status_lo_n)
    ) else $error("send-status flag disagrees with status pins");

    AST_START_LOW: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_req_taken |-> (o_busy && o_status_oe && (!o_cycle_status_hi_n || !o_cycle_status_lo_n))
    ) else $error("taken cycle did not start with status low");

    AST_START_ONLY_TAKEN: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(o_send_status_state) |-> o_req_taken
    ) else $error("status went low without a taken request");

    AST_NO_RESERVED: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (!o_code_or_int_ack_select && !o_mem_io_select && o_send_status_state)
        |-> ({o_cycle_status_hi_n, o_cycle_status_lo_n} == BCSE_STATUS_INT_ACK)
    ) else $error("reserved status code on the pins");

    AST_INTA_CODE: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (state_q == BCSE_IDLE && i_req_valid && !i_hold_ack && !i_req_code_or_int_ack_select &&
         !i_req_mem_io_select && i_req_status == BCSE_STATUS_INT_ACK)
        |=> (o_req_taken && !o_cycle_status_hi_n && !o_cycle_status_lo_n)
    ) else $error("interrupt acknowledge not issued as 00");

    AST_REFUSE_BAD: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_req_valid && req_bad) |=> (o_req_refused && !o_req_taken)
    ) else $error("reserved or idle code not refused");

    AST_SEND_LEN: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (o_req_taken && SEND_CYCLES == 4'h1 && !i_hold_ack) |=> !o_send_status_state
    ) else $error("send-status phase longer than one cycle");

    COV_INTA: cover property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_req_taken && !o_cycle_status_hi_n && !o_cycle_status_lo_n && !o_code_or_int_ack_select
    );
    COV_HOLD_MID: cover property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_busy ##1 !o_status_oe
    );
    COV_REFUSED: cover property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_req_refused
    );
endmodule // bcse_status_encoder
`default_nettype wire

/* tb/bcse_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bcse_ctrl_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // status and select wires as the board sees them
    input wire logic i_status_hi_n,
    input wire logic i_status_lo_n,
    input wire logic i_code_or_int_ack_select,
    input wire logic i_mem_io_select,
    // decoded command, one pulse per int-ack status phase
    output logic o_int_ack_cmd
);
    // samples every clock; reserved and idle codes start nothing, so only 0000 counts
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) o_int_ack_cmd <= 1'b0;
        else o_int_ack_cmd <= ({i_code_or_int_ack_select, i_mem_io_select,
                                i_status_hi_n, i_status_lo_n} == 4'h0);
    end
endmodule // bcse_ctrl_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import bcse_pkg::*;
    logic clk = 0, rst_n = 0, valid = 0, cia = 0, mio = 0, hold = 0, c, m; // driven inputs
    logic [1:0] st = 2'h0, s;
    logic [31:0] rnd; // raw random word, sliced into request fields
    logic taken, refused, busy, hi_n, lo_n, oe, o_cia, o_mio, sst, cmd; // observed outputs
    wire w_hi = oe ? hi_n : 1'b1; // pull-up holds a released pin at one
    wire w_lo = oe ? lo_n : 1'b1;
    int failures = 0, num_checks = 0, cyc = 0, acks = 0, exp_acks = 0;
    integer seed = 32'h49ef; // random seed
    logic [5:0] expq [$]; // {taken, refused, selects, pins} per request
    bcse_status_encoder uut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_req_valid(valid),
        .i_req_code_or_int_ack_select(cia), .i_req_mem_io_select(mio), .i_req_status(st), .i_hold_ack(hold),
        .o_req_taken(taken), .o_req_refused(refused), .o_busy(busy), .o_cycle_status_hi_n(hi_n),
        .o_cycle_status_lo_n(lo_n), .o_status_oe(oe), .o_code_or_int_ack_select(o_cia),
        .o_mem_io_select(o_mio), .o_send_status_state(sst));
    bcse_ctrl_model ctrl (.i_ref_clk(clk), .i_reset_n(rst_n), .i_status_hi_n(w_hi), .i_status_lo_n(w_lo),
        .i_code_or_int_ack_select(o_cia), .i_mem_io_select(o_mio), .o_int_ack_cmd(cmd));
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // accepted codes: never 11, never reserved with both selects low
    function automatic logic good(logic fc, logic fm, logic [1:0] fs);
        return fs != 2'h3 && !({fc, fm} == 2'h0 && (fs == 2'h1 || fs == 2'h2));
    endfunction
    // one request cycle, called at a falling edge; valid drops at the answer, then one idle cycle
    // passes so a following call never raises valid in the step that lowered it
    task automatic req(logic rc, logic rm, logic [1:0] rs, logic ok);
        valid = 1;
        cia = rc;
        mio = rm;
        st = rs;
        expq.push_back({ok, !ok, ok ? {rc, rm, rs} : 4'hf});
        if (ok && {rc, rm, rs} == 4'h0) exp_acks++;
        @(negedge clk);
        valid = 0;
        @(negedge clk);
    endtask
    task automatic wait_idle();
        repeat (8) if (busy === 1'b1) @(negedge clk);
    endtask
    // answer monitor; pins are only meaningful on an accepted request
    always @(negedge clk) begin
        logic [5:0] e, g;
        if (cmd === 1'b1) acks++;
        if ((taken | refused) === 1'b1) begin
            if (expq.size() == 0) check("answer_queue", 8'h0, 8'h1);
            else begin
                e = expq.pop_front();
                // selects and pins only mean something on a taken request
                g = {taken, refused, taken ? {o_cia, o_mio, w_hi, w_lo} : 4'hf};
                check("answer", {2'h0, e}, {2'h0, g});
                if (e[5]) check("send_state", {7'h0, e[1:0] != 2'h3}, {7'h0, sst});
            end
        end
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        req(1'b0, 1'b0, 2'h0, 1'b1);
        @(negedge clk);
        check("cmd_phase", 8'h7, {5'h0, busy, w_hi, w_lo});
        @(negedge clk);
        @(negedge clk);
        check("back_idle", 8'h3, {5'h0, busy, w_hi, w_lo});
        $display("test walk done");
        req(1'b0, 1'b1, 2'h1, 1'b1);
        req(1'b0, 1'b1, 2'h2, 1'b0);
        wait_idle();
        for (int i = 0; i < 16; i++) begin
            req(i[3], i[2], i[1:0], good(i[3], i[2], i[1:0]));
            wait_idle();
        end
        $display("test code table done");
        hold = 1;
        @(negedge clk);
        check("released", 8'h3, {5'h0, oe, w_hi, w_lo});
        req(1'b0, 1'b0, 2'h0, 1'b0);
        hold = 0;
        @(negedge clk);
        req(1'b1, 1'b1, 2'h0, 1'b1);
        hold = 1; // lands in the command phase
        @(negedge clk);
        check("abort_cmd", 8'h3, {3'h0, o_cia, oe, busy, w_hi, w_lo});
        hold = 0;
        @(negedge clk);
        // hold rises as valid drops, so it meets the one-cycle send-status phase
        valid = 1;
        cia = 1'b1;
        mio = 1'b0;
        st = 2'h1;
        expq.push_back({2'b10, 1'b1, 1'b0, 2'h1});
        @(negedge clk);
        valid = 0;
        hold = 1;
        @(negedge clk);
        check("abort_send", 8'h3, {3'h0, o_cia, oe, busy, w_hi, w_lo});
        hold = 0;
        @(negedge clk);
        $display("test hold done");
        repeat (40) begin
            rnd = $random(seed);
            c = rnd[0];
            m = rnd[1];
            s = rnd[3:2];
            req(c, m, s, good(c, m, s));
            wait_idle();
        end
        repeat (3) @(negedge clk);
        check("int_ack_cmds", exp_acks[7:0], acks[7:0]);
        check("queue_left", 8'h0, 8'(expq.size()));
        $display("test random done");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
